//--- tb/tb_top.sv
// Purpose: self-checking bench for usilc_top
// Assumes: serial master near 1/23 of the clock, debounce cut to 20 cycles
// Notes:   expectations come from integer reference state
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_total++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
    logic clock_in = 0, rst_n_in = 0, scl = 1, sda_m = 1, plug = 0, flip = 0;
    logic [1:0] lvl = 0, fault = 0;
    logic sda_out, sda_oe_out, pres, ov, uv, reg_on, chg_on, bus_on, irq;
    logic [2:0] cc1, cc2;
    logic [3:0] lim;
    logic [7:0] q;
    int err_total = 0, samples_checked = 0, seed = 32'h6561, exp_lim = 1, host = 0;
    wire sda_w = sda_m & ~sda_oe_out; // open-drain wired level
    always #2.5 clock_in = ~clock_in;
    usilc_source_model usilc_source_model_inst (.plug_in(plug), .flip_in(flip), .level_in(lvl),
        .fault_in(fault), .present_out(pres), .ov_out(ov), .uv_out(uv), .cc1_out(cc1),
        .cc2_out(cc2));
    usilc_top #(.DEBOUNCE_CYCLES(20)) usilc_top_inst (.clock_in, .rst_n_in, .scl_in(scl),
        .sda_in(sda_w), .sda_out, .sda_oe_out, .supply_present_in(pres), .overvoltage_in(ov),
        .undervoltage_in(uv), .cc1_cmp_in(cc1), .cc2_cmp_in(cc2), .input_limit_code_out(lim),
        .regulator_on_out(reg_on), .charge_enable_out(chg_on),
        .bus_supply_output_on_out(bus_on), .irq_out(irq));
    // ----------------------------------------
    // serial master, edges kept apart so the synchroniser never sees two at once
    // ----------------------------------------
    task automatic w(int n); repeat (n) @(negedge clock_in); endtask
    task automatic bit_io(input logic b, output logic r);
        sda_m = b; w(10); scl = 1; w(10); r = sda_w; scl = 0; w(3);
    endtask
    task automatic byte_io(input logic [7:0] d, output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
        bit_io(1'b1, a);
    endtask
    task automatic start; sda_m = 1; w(10); scl = 1; w(10); sda_m = 0; w(10); scl = 0; w(3);
    endtask
    task automatic stop; sda_m = 0; w(10); scl = 1; w(10); sda_m = 1; w(10); endtask
    task automatic acc(input logic [7:0] ofs, input logic [7:0] d, input logic rd);
        logic [7:0] x;
        logic a;
        start; byte_io(8'hd6, x, a); byte_io(ofs, x, a);
        if (rd) begin start; byte_io(8'hd7, x, a); byte_io(8'hff, q, a); end
        else byte_io(d, x, a);
        stop;
    endtask
    task automatic tally_and_finish;
        $display("mismatches %0d of %0d checks", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // watchdog, well past the expected run length
    initial begin #400000; err_total++; tally_and_finish; end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        w(20); rst_n_in = 1; w(12);
        `CHK(lim, 4'h1)
        acc(8'h00, 0, 1); `CHK(q, 8'h00)
        `CHK(sda_out, 1'b0)
        acc(8'h03, 0, 1); `CHK(q, 8'h00)
        acc(8'h04, 8'h03, 0); plug = 1;
        // every level on both orientations, each change must raise an event
        for (int k = 0; k < 8; k++) begin
            flip = k[2]; lvl = k[1:0]; w(40); acc(8'h05, 0, 1);
            `CHK(q, flip ? {4'h0, lvl, 2'h0} : {6'h0, lvl})
            `CHK(irq, k != 0)
            acc(8'h06, 8'h03, 0); `CHK(irq, 1'b0)
        end
        lvl = 1; w(10); lvl = 3; w(40); acc(8'h05, 0, 1);
        `CHK({irq, q}, 9'h00c)
        acc(8'h03, 8'hff, 0); `CHK({chg_on, bus_on}, 2'b01)
        acc(8'h07, 0, 1); `CHK(q, 8'h31)
        acc(8'h03, 0, 1); `CHK(q, 8'h01)
        acc(8'h03, 0, 0); `CHK(chg_on, 1'b1)
        host = $random(seed) & 15;
        if (host == 1) host = 0;
        acc(8'h02, 8'h05, 0); exp_lim = 5; `CHK(lim, exp_lim[3:0])
        acc(8'h01, 8'hf0 | host[7:0], 0); `CHK(lim, exp_lim[3:0])
        acc(8'h01, 0, 1); `CHK(q, host[7:0])
        acc(8'h00, 8'hfe, 0); `CHK(lim, exp_lim[3:0])
        acc(8'h00, 8'h01, 0); exp_lim = host; `CHK(lim, exp_lim[3:0])
        acc(8'h04, 8'h00, 0); // interrupt off: the unplug crossing may only flag
        plug = 0; w(10); exp_lim = 5; `CHK(lim, exp_lim[3:0])
        `CHK(irq, 1'b0)
        acc(8'h06, 0, 1); `CHK(q, 8'h02)
        plug = 1;
        for (int f = 3; f >= 0; f--) begin
            fault = f[1:0]; w(10); `CHK(reg_on, f == 0)
            `CHK(bus_on, f == 0)
        end
        rst_n_in = 0; w(3); rst_n_in = 1; w(12); `CHK(lim, 4'h1)
        acc(8'h02, 0, 1); `CHK(q, 8'h01)
        tally_and_finish;
    end
endmodule // tb_top

//--- tb/usilc_source_model.sv
// Purpose: usb power source seen on the supply and cc pins
// Assumes: level_in is the cc capability code, flip_in the plug orientation
// Notes:   released cc lines sit at the pull-down level, never at the last value
`timescale 1ns/1ps
module usilc_source_model (
    input  wire logic       plug_in,
    input  wire logic       flip_in,
    input  wire logic [1:0] level_in,
    input  wire logic [1:0] fault_in,
    output logic            present_out,
    output logic            ov_out,
    output logic            uv_out,
    output logic      [2:0] cc1_out,
    output logic      [2:0] cc2_out
);
    logic [2:0] therm;
    // thermometer over the three thresholds, zero when unplugged
    assign therm = plug_in ? (3'h7 >> (2'h3 - level_in)) : 3'h0;
    // only the pulled-up line carries the level
    assign cc1_out = flip_in ? 3'h0 : therm;
    assign cc2_out = flip_in ? therm : 3'h0;
    // faults only on command, and only while a cable is in
    assign present_out = plug_in;
    assign ov_out = plug_in & fault_in[0];
    assign uv_out = plug_in & fault_in[1];
endmodule // usilc_source_model

//--- verilog/usilc_debounce.sv
// Purpose: restartable debounce of one CC line comparator group
// Assumes: input already synchronised
// Notes:   held at zero while supply absent
`timescale 1ns/1ps
module usilc_debounce #(
    parameter int CYCLES = usilc_pkg::CC_DEBOUNCE_CYCLES
) (
    input  wire logic       clock_in,
    input  wire logic       rst_n_in,
    input  wire logic       enable_in,
    input  wire logic [2:0] raw_in,
    output logic      [2:0] stable_out
);
    localparam logic [usilc_pkg::DEB_WIDTH-1:0] LAST =
        usilc_pkg::DEB_WIDTH'(CYCLES - 1);

    typedef struct packed {
        logic [2:0]                    seen;
        logic [usilc_pkg::DEB_WIDTH-1:0] cnt;
        logic [2:0]                    q;
    } usilc_deb_type;

    usilc_deb_type s_ff;
    usilc_deb_type nxt_s;

    // -------------------------------------------------------------
    // counter restarts on any change of the raw level
    // -------------------------------------------------------------
    always_comb begin
        nxt_s      = s_ff;
        nxt_s.seen = raw_in;
        if (!enable_in) begin
            nxt_s = '0; // no supply: report no connection
        end else if (raw_in != s_ff.seen) begin
            nxt_s.cnt = '0; // restart on glitch
        end else if (s_ff.cnt == LAST) begin
            nxt_s.q = s_ff.seen; // held a full interval
        end else begin
            nxt_s.cnt = s_ff.cnt + 1'b1;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign stable_out = s_ff.q;

    chk_deb_restart: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (enable_in && raw_in != s_ff.seen) |=> (s_ff.cnt == '0))
        else $error("debounce counter did not restart");
    chk_deb_only_expiry: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (enable_in && s_ff.q != nxt_s.q) |-> (s_ff.cnt == LAST))
        else $error("debounced level moved before expiry");
endmodule // usilc_debounce

//--- verilog/usilc_pkg.sv
// Purpose: shared constants for the supply input limit control block
// Assumes: 200 MHz device clock, byte-wide registers behind a two-wire serial slave
// Notes:   all offsets, timing counts, limit reset values and the apply, suspend and CC field positions live here
package usilc_pkg;

    // -------------------------------------------------------------
    // register offsets
    // -------------------------------------------------------------
    localparam logic [7:0] OFS_LIMIT_APPLY   = 8'h00;
    localparam logic [7:0] OFS_HOST_LIMIT    = 8'h01;
    localparam logic [7:0] OFS_STARTUP_LIMIT = 8'h02;
    localparam logic [7:0] OFS_SUSPEND       = 8'h03;
    localparam logic [7:0] OFS_EVENT_ENABLE  = 8'h04;
    localparam logic [7:0] OFS_CC_DETECT     = 8'h05;
    localparam logic [7:0] OFS_EVENT_FLAGS   = 8'h06;
    localparam logic [7:0] OFS_SUPPLY_STATUS = 8'h07;

    // -------------------------------------------------------------
    // field positions and reset values
    // -------------------------------------------------------------
    localparam int         BIT_APPLY          = 0;
    localparam int         BIT_SUSPEND        = 0;
    localparam int         CC1_LSB            = 0;
    localparam int         CC2_LSB            = 2;
    localparam logic [3:0] HOST_LIMIT_RESET   = 4'h0;
    localparam logic [3:0] STARTUP_LIMIT_RESET = 4'h1; // code 1 = 100 mA
    localparam logic [3:0] LIMIT_CODE_100MA   = 4'h1;
    localparam logic [1:0] CC_NONE            = 2'h0;
    localparam logic [1:0] CC_DEFAULT_USB     = 2'h1;
    localparam logic [1:0] CC_1A5             = 2'h2;
    localparam logic [1:0] CC_3A              = 2'h3;

    // serial slave address, arbitrary value
    localparam logic [6:0] TWI_ADDRESS        = 7'h6b;

    // -------------------------------------------------------------
    // timing
    // -------------------------------------------------------------
    localparam int CLOCK_KHZ          = 200000;
    localparam int CC_DEBOUNCE_MS     = 15;
    localparam int CC_DEBOUNCE_CYCLES = CC_DEBOUNCE_MS * CLOCK_KHZ;
    localparam int DEB_WIDTH          = 22;

    // serial slave states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_PTR,
        ST_WDATA,
        ST_ACK,
        ST_RDATA,
        ST_RACK
    } usilc_twi_state_type;

endpackage

//--- verilog/usilc_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs asynchronous to clock_in
// Notes:   output only moves when stages two and three agree
`timescale 1ns/1ps
module usilc_sync #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] IDLE  = '0
) (
    input  wire logic             clock_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } usilc_sync_type;

    usilc_sync_type s_ff;
    usilc_sync_type nxt_s;

    // -------------------------------------------------------------
    // stage one feeds stage two only
    // -------------------------------------------------------------
    always_comb begin
        nxt_s    = s_ff;
        nxt_s.s1 = pin_in;
        nxt_s.s2 = s_ff.s1;
        nxt_s.s3 = s_ff.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (s_ff.s2[i] == s_ff.s3[i]) begin
                nxt_s.q[i] = s_ff.s3[i];
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_ff <= {IDLE, IDLE, IDLE, IDLE}; // idle pin level: no false edge after reset
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign level_out = s_ff.q;
endmodule // usilc_sync

//--- verilog/usilc_top.sv
// Purpose: supply input limit, CC detection, protection and suspend control
// Assumes: registers reached over a two-wire serial slave on scl/sda pins
// Notes:   analog comparators arrive as asynchronous level pins
`timescale 1ns/1ps
module usilc_top #(
    parameter int DEBOUNCE_CYCLES = usilc_pkg::CC_DEBOUNCE_CYCLES
) (
    input  wire logic       clock_in,
    input  wire logic       rst_n_in,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_out,
    input  wire logic       supply_present_in,
    input  wire logic       overvoltage_in,
    input  wire logic       undervoltage_in,
    input  wire logic [2:0] cc1_cmp_in,
    input  wire logic [2:0] cc2_cmp_in,
    output logic      [3:0] input_limit_code_out,
    output logic            regulator_on_out,
    output logic            charge_enable_out,
    output logic            bus_supply_output_on_out,
    output logic            irq_out
);
    typedef struct packed {
        usilc_pkg::usilc_twi_state_type st;
        logic [2:0] bitcnt;
        logic [7:0] shreg;
        logic [7:0] ptr;
        logic       rd;
        logic       done;
        logic       addr_ack;
        logic       sda_oe;
        logic       scl_q;
        logic       sda_q;
        logic [3:0] host_lim;
        logic [3:0] start_lim;
        logic       use_host;
        logic       suspend;
        logic [1:0] irq_en;
        logic [1:0] events;
        logic [1:0] cc1_lvl;
        logic [1:0] cc2_lvl;
        logic       pres_q;
        logic [3:0] ilim;
        logic       reg_on;
        logic       chg_on;
        logic       bus_on;
        logic       irq;
    } usilc_state_type;

    localparam usilc_state_type RESET_STATE = '{
        st: usilc_pkg::ST_IDLE, start_lim: usilc_pkg::STARTUP_LIMIT_RESET,
        host_lim: usilc_pkg::HOST_LIMIT_RESET, ilim: usilc_pkg::LIMIT_CODE_100MA,
        scl_q: 1'b1, sda_q: 1'b1, default: '0};

    usilc_state_type s_ff;
    usilc_state_type nxt_s;
    logic [10:0]     pins_f;
    logic [2:0]      cc1_deb;
    logic [2:0]      cc2_deb;
    logic            scl_f;
    logic            sda_f;
    logic            pres_f;
    logic            ovp_f;
    logic            uv_f;
    logic            scl_rise;
    logic            scl_fall;
    logic            wr_fire;
    logic            apply_wr;
    logic            sus_clear_wr;
    logic [1:0]      cc1_code;
    logic [1:0]      cc2_code;

    // -------------------------------------------------------------
    // pin synchronisers and CC debounce
    // -------------------------------------------------------------
    usilc_sync #(.WIDTH(11), .IDLE(11'h003)) u_sync ( // scl and sda idle high
        .clock_in  (clock_in),
        .rst_n_in  (rst_n_in),
        .pin_in    ({cc2_cmp_in, cc1_cmp_in, undervoltage_in, overvoltage_in,
                     supply_present_in, sda_in, scl_in}),
        .level_out (pins_f)
    );

    // detection needs no command, only supply presence
    usilc_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_deb_cc1 (
        .clock_in   (clock_in),
        .rst_n_in   (rst_n_in),
        .enable_in  (pres_f),
        .raw_in     (pins_f[7:5]),
        .stable_out (cc1_deb)
    );
    usilc_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_deb_cc2 (
        .clock_in   (clock_in),
        .rst_n_in   (rst_n_in),
        .enable_in  (pres_f),
        .raw_in     (pins_f[10:8]),
        .stable_out (cc2_deb)
    );

    assign scl_f    = pins_f[0];
    assign sda_f    = pins_f[1];
    assign pres_f   = pins_f[2];
    assign ovp_f    = pins_f[3];
    assign uv_f     = pins_f[4];
    assign scl_rise = scl_f && !s_ff.scl_q;
    assign scl_fall = !scl_f && s_ff.scl_q;
    assign wr_fire  = scl_fall && s_ff.done && s_ff.st == usilc_pkg::ST_WDATA;
    assign apply_wr = wr_fire && s_ff.ptr == usilc_pkg::OFS_LIMIT_APPLY
                      && s_ff.shreg[usilc_pkg::BIT_APPLY];
    assign sus_clear_wr = wr_fire && s_ff.ptr == usilc_pkg::OFS_SUSPEND
                          && !s_ff.shreg[usilc_pkg::BIT_SUSPEND];

    // thermometer comparators (0.2, 0.66, 1.23 V) to capability code
    function automatic logic [1:0] usilc_code(input logic [2:0] t);
        logic [1:0] c;
        c = usilc_pkg::CC_NONE;
        if (t[2]) begin
            c = usilc_pkg::CC_3A;
        end else if (t[1]) begin
            c = usilc_pkg::CC_1A5;
        end else if (t[0]) begin
            c = usilc_pkg::CC_DEFAULT_USB;
        end
        return c;
    endfunction

    // only the pulled-up line reports, the other stays idle
    assign cc1_code = usilc_code(cc1_deb);
    assign cc2_code = (cc1_code != usilc_pkg::CC_NONE) ? usilc_pkg::CC_NONE
                      : usilc_code(cc2_deb);

    // -------------------------------------------------------------
    // register read map, reserved bits zero
    // -------------------------------------------------------------
    function automatic logic [7:0] usilc_read(input usilc_state_type s);
        logic [7:0] d;
        d = 8'h00;
        case (s.ptr)
            usilc_pkg::OFS_HOST_LIMIT:    d = {4'h0, s.host_lim};
            usilc_pkg::OFS_STARTUP_LIMIT: d = {4'h0, s.start_lim};
            usilc_pkg::OFS_SUSPEND:       d = {7'h00, s.suspend};
            usilc_pkg::OFS_EVENT_ENABLE:  d = {6'h00, s.irq_en};
            usilc_pkg::OFS_CC_DETECT:     d = {4'h0, s.cc2_lvl, s.cc1_lvl};
            usilc_pkg::OFS_EVENT_FLAGS:   d = {6'h00, s.events};
            usilc_pkg::OFS_SUPPLY_STATUS: d = {2'h0, s.bus_on, s.suspend,
                                               uv_f && pres_f, ovp_f, 1'b0, pres_f};
            default:                      d = 8'h00; // apply task reads zero
        endcase
        return d;
    endfunction

    // -------------------------------------------------------------
    // serial slave, register writes and supply control
    // -------------------------------------------------------------
    always_comb begin
        nxt_s       = s_ff;
        nxt_s.scl_q = scl_f;
        nxt_s.sda_q = sda_f;
        if (scl_rise && s_ff.st inside {usilc_pkg::ST_ADDR, usilc_pkg::ST_PTR,
                                        usilc_pkg::ST_WDATA}) begin
            nxt_s.shreg  = {s_ff.shreg[6:0], sda_f};
            nxt_s.bitcnt = s_ff.bitcnt + 3'h1;
            nxt_s.done   = (s_ff.bitcnt == 3'h7);
        end
        if (scl_fall) begin
            case (s_ff.st)
                usilc_pkg::ST_ADDR: begin
                    if (s_ff.done && s_ff.shreg[7:1] == usilc_pkg::TWI_ADDRESS) begin
                        nxt_s.rd     = s_ff.shreg[0];
                        nxt_s.addr_ack = 1'b1;
                        nxt_s.sda_oe = 1'b1;
                        nxt_s.st     = usilc_pkg::ST_ACK;
                    end else if (s_ff.done) begin
                        nxt_s.st = usilc_pkg::ST_IDLE;
                    end
                end
                usilc_pkg::ST_PTR: begin
                    if (s_ff.done) begin
                        nxt_s.ptr    = s_ff.shreg;
                        nxt_s.sda_oe = 1'b1;
                        nxt_s.st     = usilc_pkg::ST_ACK;
                    end
                end
                usilc_pkg::ST_WDATA: begin
                    if (s_ff.done) begin
                        case (s_ff.ptr)
                            usilc_pkg::OFS_HOST_LIMIT:    nxt_s.host_lim = s_ff.shreg[3:0];
                            usilc_pkg::OFS_STARTUP_LIMIT: nxt_s.start_lim = s_ff.shreg[3:0];
                            usilc_pkg::OFS_SUSPEND:       nxt_s.suspend = s_ff.shreg[0];
                            usilc_pkg::OFS_EVENT_ENABLE:  nxt_s.irq_en = s_ff.shreg[1:0];
                            default:                      nxt_s.irq_en = s_ff.irq_en;
                        endcase
                        nxt_s.ptr    = s_ff.ptr + 8'h01;
                        nxt_s.sda_oe = 1'b1;
                        nxt_s.st     = usilc_pkg::ST_ACK;
                    end
                end
                usilc_pkg::ST_ACK, usilc_pkg::ST_RACK: begin // after either ack bit: next byte at once
                    nxt_s.done   = 1'b0;
                    nxt_s.addr_ack = 1'b0;
                    nxt_s.bitcnt = 3'h0;
                    if (s_ff.rd) begin
                        nxt_s.shreg  = usilc_read(s_ff);
                        nxt_s.sda_oe = !nxt_s.shreg[7];
                        nxt_s.ptr    = s_ff.ptr + 8'h01;
                        nxt_s.st     = usilc_pkg::ST_RDATA;
                    end else begin
                        nxt_s.sda_oe = 1'b0;
                        nxt_s.st     = s_ff.addr_ack ? usilc_pkg::ST_PTR : usilc_pkg::ST_WDATA;
                    end
                end
                usilc_pkg::ST_RDATA: begin
                    if (s_ff.bitcnt == 3'h7) begin
                        nxt_s.sda_oe = 1'b0;
                        nxt_s.st     = usilc_pkg::ST_RACK;
                    end else begin
                        nxt_s.shreg  = {s_ff.shreg[6:0], 1'b0};
                        nxt_s.sda_oe = !s_ff.shreg[6];
                        nxt_s.bitcnt = s_ff.bitcnt + 3'h1;
                    end
                end
                default: nxt_s.sda_oe = 1'b0;
            endcase
        end
        if (scl_rise && s_ff.st == usilc_pkg::ST_RACK && sda_f) begin
            nxt_s.st = usilc_pkg::ST_IDLE; // master nack ends the read
        end
        // start and stop while scl high override everything
        if (scl_f && s_ff.scl_q && s_ff.sda_q && !sda_f) begin
            nxt_s.st     = usilc_pkg::ST_ADDR;
            nxt_s.bitcnt = 3'h0;
            nxt_s.done   = 1'b0;
            nxt_s.sda_oe = 1'b0;
        end else if (scl_f && s_ff.scl_q && !s_ff.sda_q && sda_f) begin
            nxt_s.st     = usilc_pkg::ST_IDLE;
            nxt_s.sda_oe = 1'b0;
        end

        // limit selection: apply task commits, removal reverts
        nxt_s.pres_q = pres_f;
        if (apply_wr) begin
            nxt_s.use_host = 1'b1;
        end
        if (!pres_f && s_ff.pres_q) begin
            nxt_s.use_host = 1'b0; // unplug wins over a same-cycle apply
        end
        nxt_s.ilim = s_ff.use_host ? s_ff.host_lim : s_ff.start_lim;

        // debounced CC levels and crossing events, set wins over clear
        nxt_s.cc1_lvl = cc1_code;
        nxt_s.cc2_lvl = cc2_code;
        if (wr_fire && s_ff.ptr == usilc_pkg::OFS_EVENT_FLAGS) begin
            nxt_s.events = s_ff.events & ~s_ff.shreg[1:0];
        end
        if (cc1_code != s_ff.cc1_lvl) begin
            nxt_s.events[0] = 1'b1;
        end
        if (cc2_code != s_ff.cc2_lvl) begin
            nxt_s.events[1] = 1'b1;
        end
        nxt_s.irq = |(s_ff.events & s_ff.irq_en);

        // protection and suspend, output stays up in suspend
        nxt_s.reg_on = pres_f && !ovp_f && !uv_f && !s_ff.suspend;
        nxt_s.chg_on = pres_f && !s_ff.suspend; // resumes only when software clears suspend
        nxt_s.bus_on = pres_f && !ovp_f && !uv_f;
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_ff <= RESET_STATE;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign sda_out                  = 1'b0;
    assign sda_oe_out               = s_ff.sda_oe;
    assign input_limit_code_out     = s_ff.ilim;
    assign regulator_on_out         = s_ff.reg_on;
    assign charge_enable_out        = s_ff.chg_on;
    assign bus_supply_output_on_out = s_ff.bus_on;
    assign irq_out                  = s_ff.irq;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    sequence usilc_commit_seq;
        apply_wr ##1 s_ff.use_host;
    endsequence

    chk_startup_in_force: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (!s_ff.use_host ##1 !s_ff.use_host) |-> (input_limit_code_out == $past(s_ff.start_lim)))
        else $error("startup limit not in force");
    chk_apply_commits: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        $rose(s_ff.use_host) |-> $past(apply_wr))
        else $error("host limit committed without apply");
    chk_apply_to_limit: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (usilc_commit_seq and (pres_f [*2])) |=> (input_limit_code_out == $past(s_ff.host_lim)))
        else $error("apply did not reach the active limit");
    chk_unplug_reverts: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (s_ff.pres_q && !pres_f) |=> !s_ff.use_host)
        else $error("unplug did not revert limit");
    chk_ovp_isolates: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (ovp_f || uv_f) |=> !regulator_on_out)
        else $error("regulator on outside voltage window");
    chk_suspend_path: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (s_ff.suspend && pres_f && !ovp_f && !uv_f) |=>
        (!regulator_on_out && !charge_enable_out && bus_supply_output_on_out))
        else $error("suspend did not isolate rail");
    chk_suspend_sticky: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (s_ff.suspend && !sus_clear_wr) |=> s_ff.suspend)
        else $error("suspend left without software clear");
    chk_event_on_cross: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (cc1_code != s_ff.cc1_lvl) |=> (s_ff.events[0] ##1 (!$past(s_ff.irq_en[0]) || irq_out)))
        else $error("crossing did not raise event");
    chk_one_line_only: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (s_ff.cc1_lvl != usilc_pkg::CC_NONE) |-> (s_ff.cc2_lvl == usilc_pkg::CC_NONE))
        else $error("both CC fields report");
endmodule // usilc_top
